// *** shared/sadc_pkg.sv ***
// Shared constants and types for the stereo audio converter control block
package sadc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_ADDR       = 8'h00;
  localparam logic [7:0]  STAT_ADDR       = 8'h04;
  localparam logic [7:0]  FALLBACK_ADDR   = 8'h08;
  localparam logic [7:0]  LEFT_PORT_ADDR  = 8'h0c;
  localparam logic [7:0]  RIGHT_PORT_ADDR = 8'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          CTRL_ENABLE_BIT  = 15;
  localparam int          CTRL_IDLE_BIT    = 13;
  localparam int          CTRL_AMP_BIT     = 12;
  localparam int          CTRL_FORMAT_BIT  = 8;
  localparam int          CTRL_DIV_LSB     = 0;
  localparam int          DIV_WIDTH        = 7;
  localparam logic [6:0]  DIV_RESET        = 7'h05;

  // ----------------------------------------------------------------
  // Status register fields, per channel, added to the channel base
  // ----------------------------------------------------------------
  localparam int          LEFT_STAT_BASE   = 8;
  localparam int          RIGHT_STAT_BASE  = 0;
  localparam int          STAT_OE_BIT      = 7;
  localparam int          STAT_MID_BIT     = 5;
  localparam int          STAT_TYPE_BIT    = 2;
  localparam int          STAT_FULL_BIT    = 1;
  localparam int          STAT_EMPTY_BIT   = 0;

  // ----------------------------------------------------------------
  // Data and timing
  // ----------------------------------------------------------------
  localparam int          SAMPLE_WIDTH     = 16;
  localparam logic [15:0] FALLBACK_RESET   = 16'h0000;
  localparam int          FIFO_DEPTH       = 4;
  localparam logic [7:0]  PERIOD_LAST      = 8'hff;  // 256 converter clocks per sample
  localparam int          NUM_CHANNELS     = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       module_enable;
    logic       idle_stop;
    logic       amp_keep_on;
    logic       sample_format_sel;
    logic [6:0] conv_clock_divider;
  } sadc_ctrl_type;

  typedef struct packed {
    logic output_enable;
    logic midpoint_enable;
    logic irq_type;
  } sadc_chan_cfg_type;

  typedef struct packed {
    logic        drive;
    logic        mid_drive;
    logic        irq;
    logic        strobe;
    logic [15:0] level;
  } sadc_chan_out_type;

endpackage : sadc_pkg

// *** testbench/sadc_asserts.sv ***
// Port-level checks for the audio converter control block
`timescale 1ns/10ps

module sadc_asserts (
  // Clock, reset, bus and sleep state
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        sleep_mode,
  // Converter side
  input wire sadc_pkg::sadc_chan_out_type left_chan,
  input wire sadc_pkg::sadc_chan_out_type right_chan,
  input wire logic                        conv_tick,
  input wire logic                        amp_enable,
  input wire logic                        converter_running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access_start;
    psel && penable && !$past(penable);
  endsequence

  // Two halted cycles, though drive and conv_tick already fall in the same cycle as converter_running
  sequence s_halted;
    !converter_running [*2];
  endsequence

  a_ready_wait: assert property (s_access_start |=> pready)
    else $error("bus answer not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("bus ready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("bus error without ready");
  a_strobe_cause: assert property (
    left_chan.strobe |-> right_chan.strobe && $past(conv_tick, 2))
    else $error("sample strobe without tick two cycles before");
  a_strobe_once: assert property (left_chan.strobe |=> !left_chan.strobe [*8])
    else $error("sample strobe repeated");
  a_level_hold: assert property (
    !left_chan.strobe |-> $stable(left_chan.level) && $stable(right_chan.level))
    else $error("level changed outside a sample point");
  a_tick_gap: assert property (conv_tick |=> !conv_tick [*3])
    else $error("converter ticks too close");
  a_tick_halted: assert property (s_halted |-> !conv_tick)
    else $error("converter tick while halted");
  a_drive_halted: assert property (
    s_halted |-> !(left_chan.drive || left_chan.mid_drive ||
                   right_chan.drive || right_chan.mid_drive))
    else $error("output driven while halted");
  a_amp_running: assert property (converter_running [*2] |-> amp_enable)
    else $error("amplifier off while running");
  a_sleep_halts: assert property (sleep_mode |=> !converter_running)
    else $error("converter running in sleep");
endmodule : sadc_asserts

// *** testbench/sadc_aux_osc.sv ***
// Free-running auxiliary oscillator for the converter clock divider
`timescale 1ns/10ps

module sadc_aux_osc #(
  parameter realtime HALF_NS = 20.0
) (
  // Oscillator output
  output logic aux_clk
);
  // 25 MHz keeps the converter clock under its ceiling at every divider setting
  initial begin
    aux_clk = 1'b0;
    #3.3;
    forever #(HALF_NS) aux_clk = ~aux_clk;
  end
endmodule : sadc_aux_osc

// *** testbench/sadc_top_test.sv ***
// Self-checking bench for the audio converter control block
`timescale 1ns/10ps

module sadc_top_test;
  logic                        pclk, presetn, psel, penable, pwrite;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata, rdat;
  logic                        pready, pslverr, rerr, aux_clk_in, idle_mode, sleep_mode;
  logic                        conv_tick, amp_enable, converter_running;
  sadc_pkg::sadc_chan_out_type left_chan, right_chan;
  int                          num_errors, checks_done, cyc, t0;
  logic [15:0]                 left_q[$], right_q[$];
  logic [15:0]                 fb, w, exp_l, exp_r;
  logic [6:0]                  divs[4] = '{7'h00, 7'h01, 7'h05, 7'h7f};

  sadc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aux_clk_in(aux_clk_in), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .left_chan(left_chan), .right_chan(right_chan),
    .conv_tick(conv_tick), .amp_enable(amp_enable), .converter_running(converter_running));
  sadc_aux_osc i_osc (.aux_clk(aux_clk_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata);
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rdat, exp, "register read");
  endtask : rd_chk

  task automatic wait_for(input logic want_strobe);
    @(posedge pclk);
    while ((want_strobe ? left_chan.strobe : conv_tick) !== 1'b1) begin
      @(posedge pclk);
    end
  endtask : wait_for

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Clock, timeout and sample monitor
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // An empty queue expects unknown, so a surplus sample always fails
  always @(posedge pclk) begin
    if (presetn === 1'b1 && left_chan.strobe === 1'b1) begin
      exp_l = (left_q.size() > 0) ? left_q.pop_front() : 16'hxxxx;
      exp_r = (right_q.size() > 0) ? right_q.pop_front() : 16'hxxxx;
      check({16'h0, left_chan.level}, {16'h0, exp_l}, "left level");
      check({16'h0, right_chan.level}, {16'h0, exp_r}, "right level");
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, idle_mode, sleep_mode} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    {cyc, num_errors, checks_done} = {32'd0, 32'd0, 32'd0};
    void'($urandom(32'h94aa1e37));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(sadc_pkg::CTRL_ADDR, 32'h0000_0005);
    rd_chk(sadc_pkg::STAT_ADDR, 32'h0000_0101);
    rd_chk(sadc_pkg::FALLBACK_ADDR, 32'h0);
    rd_chk(8'h14, 32'h0);
    check({31'h0, rerr}, 32'h1, "unmapped error");
    foreach (divs[i]) begin
      apb(1'b1, sadc_pkg::CTRL_ADDR, {16'h0, 16'h8000 | {9'h0, divs[i]}});
      wait_for(1'b0);
      wait_for(1'b0);
      t0 = cyc;
      wait_for(1'b0);
      check(32'(cyc - t0), 32'(8 * (int'(divs[i]) + 1)), "tick spacing");
    end
    apb(1'b1, sadc_pkg::CTRL_ADDR, 32'h0);
    for (int f = 0; f < 2; f++) begin
      fb = 16'($urandom);
      apb(1'b1, sadc_pkg::FALLBACK_ADDR, {16'hffff, fb});
      rd_chk(sadc_pkg::FALLBACK_ADDR, {16'h0, fb});
      apb(1'b1, sadc_pkg::STAT_ADDR, 32'h0000_8420);
      for (int k = 0; k < 5; k++) begin
        w = (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : (k == 2) ? 16'hffff : 16'($urandom);
        apb(1'b1, sadc_pkg::LEFT_PORT_ADDR, {16'h0, w});
        if (k < 4) left_q.push_back(w ^ {f[0], 15'h0});
      end
      rd_chk(sadc_pkg::LEFT_PORT_ADDR, {16'h0, w});
      left_q.push_back(fb ^ {f[0], 15'h0});
      rd_chk(sadc_pkg::STAT_ADDR, 32'h0000_8621);
      check({30'h0, left_chan.irq, right_chan.irq}, 32'h1, "irq when full");
      w = 16'($urandom);
      apb(1'b1, sadc_pkg::RIGHT_PORT_ADDR, {16'h0, w});
      right_q.push_back(w ^ {f[0], 15'h0});
      repeat (4) right_q.push_back(fb ^ {f[0], 15'h0});
      apb(1'b1, sadc_pkg::CTRL_ADDR, {16'h0, 16'h8000 | {7'h0, f[0], 8'h0}});
      wait_for(1'b1);
      t0 = cyc;
      check({28'h0, left_chan.drive, left_chan.mid_drive, right_chan.drive, right_chan.mid_drive},
            32'h9, "drive enables");
      repeat (4) begin
        wait_for(1'b1);
        check(32'(cyc - t0), 32'd2048, "sample period");
        t0 = cyc;
      end
      apb(1'b1, sadc_pkg::CTRL_ADDR, 32'h0);
      check(32'(left_q.size() + right_q.size()), 32'h0, "samples left over");
      check({30'h0, left_chan.irq, right_chan.irq}, 32'h3, "irq when drained");
      rd_chk(sadc_pkg::STAT_ADDR, 32'h0000_8521);
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, sadc_pkg::CTRL_ADDR, {16'h0, 16'ha000 | {3'h0, k[0], 12'h0}});
      idle_mode  <= ~k[1];
      sleep_mode <= k[1];
      repeat (3) @(posedge pclk);
      check({30'h0, converter_running, amp_enable}, {31'h0, k[0]}, "halted");
      idle_mode  <= 1'b0;
      sleep_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      check({30'h0, converter_running, amp_enable}, 32'h3, "resumed");
    end
    apb(1'b1, sadc_pkg::CTRL_ADDR, 32'h0000_8000);
    idle_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    check({31'h0, converter_running}, 32'h1, "runs through idle");
    tally_and_finish();
  end
endmodule : sadc_top_test

bind sadc_top sadc_asserts i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .sleep_mode(sleep_mode), .left_chan(left_chan), .right_chan(right_chan),
  .conv_tick(conv_tick), .amp_enable(amp_enable), .converter_running(converter_running)
);

// *** verilog/sadc_top.sv ***
// Control logic of a stereo 16-bit audio converter: APB registers, FIFOs, clock divider
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps

module sadc_top (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Auxiliary oscillator and power state
  input  wire logic                        aux_clk_in,
  input  wire logic                        idle_mode,
  input  wire logic                        sleep_mode,
  // Converter side
  output sadc_pkg::sadc_chan_out_type      left_chan,
  output sadc_pkg::sadc_chan_out_type      right_chan,
  output logic                             conv_tick,
  output logic                             amp_enable,
  output logic                             converter_running
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sadc_pkg::sadc_ctrl_type     ctrl;
  sadc_pkg::sadc_chan_cfg_type chan_cfg [sadc_pkg::NUM_CHANNELS];
  logic [15:0]                 fallback_value;
  logic [15:0]                 last_port_word [sadc_pkg::NUM_CHANNELS];

  logic                        access;
  logic                        wr_en;
  logic                        addr_ok;
  logic [31:0]                 next_rdata;
  logic [15:0]                 stat_word;
  logic [sadc_pkg::NUM_CHANNELS-1:0] port_write;
  logic [sadc_pkg::NUM_CHANNELS-1:0] fifo_full;
  logic [sadc_pkg::NUM_CHANNELS-1:0] fifo_empty;

  // ----------------------------------------------------------------
  // Auxiliary clock synchroniser and edge detect
  // ----------------------------------------------------------------
  // The auxiliary oscillator is sampled, so it must run below a quarter of pclk.
  logic        aux_meta;
  logic        aux_sync;
  logic        aux_prev;
  logic        aux_tick;
  logic        run;
  logic [6:0]  div_count;
  logic [7:0]  phase;
  logic        sample_point;
  logic        sample_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_meta <= 1'b0;
      aux_sync <= 1'b0;
      aux_prev <= 1'b0;
    end else begin
      aux_meta <= aux_clk_in;
      aux_sync <= aux_meta;
      aux_prev <= aux_sync;
    end
  end

  assign aux_tick = aux_sync & ~aux_prev;

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  assign run = ctrl.module_enable
             & ~(idle_mode & ctrl.idle_stop)
             & ~sleep_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_running <= 1'b0;
      amp_enable        <= 1'b0;
    end else begin
      converter_running <= run;
      // Amplifier stays up while halted only when software asks for it
      amp_enable        <= ctrl.module_enable & (run | ctrl.amp_keep_on);
    end
  end

  // ----------------------------------------------------------------
  // Converter clock divider and sample period counter
  // ----------------------------------------------------------------
  // Counters restart when the converter halts, so the first period after
  // enabling is always a full one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 7'h00;
      conv_tick <= 1'b0;
    end else if (!run) begin
      div_count <= 7'h00;
      conv_tick <= 1'b0;
    end else if (aux_tick) begin
      if (div_count >= ctrl.conv_clock_divider) begin
        div_count <= 7'h00;
        conv_tick <= 1'b1;
      end else begin
        div_count <= div_count + 7'h01;
        conv_tick <= 1'b0;
      end
    end else begin
      conv_tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 8'h00;
    end else if (!run) begin
      phase <= 8'h00;
    end else if (conv_tick) begin
      phase <= phase + 8'h01;
    end
  end

  // One sample point per 256 converter clocks; 100 ksps needs 25.6 MHz
  assign sample_point = run & conv_tick & (phase == sadc_pkg::PERIOD_LAST);

  // The taken word is registered once before it reaches the outputs, so the
  // strobe is delayed by the same cycle to stand together with its level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_d <= 1'b0;
    end else begin
      sample_d <= sample_point;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel FIFO and output stage
  // ----------------------------------------------------------------
  sadc_pkg::sadc_chan_out_type chan_q [sadc_pkg::NUM_CHANNELS];

  genvar ch;
  generate
    for (ch = 0; ch < sadc_pkg::NUM_CHANNELS; ch = ch + 1) begin : g_chan
      logic [15:0] mem [sadc_pkg::FIFO_DEPTH];
      logic [1:0]  wr_ptr;
      logic [1:0]  rd_ptr;
      logic [2:0]  count;
      logic        push;
      logic        pop;
      logic [15:0] cur_word;
      logic [15:0] next_word;
      logic [15:0] level;

      assign fifo_full[ch]  = (count == 3'(sadc_pkg::FIFO_DEPTH));
      assign fifo_empty[ch] = (count == 3'h0);
      assign push = port_write[ch] & ~fifo_full[ch];
      assign pop  = sample_point & ~fifo_empty[ch];

      always_ff @(posedge pclk) begin
        if (push) begin
          mem[wr_ptr] <= pwdata[15:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wr_ptr <= 2'h0;
          rd_ptr <= 2'h0;
          count  <= 3'h0;
        end else begin
          if (push) begin
            wr_ptr <= wr_ptr + 2'h1;
          end
          if (pop) begin
            rd_ptr <= rd_ptr + 2'h1;
          end
          case ({push, pop})
            2'b10:   count <= count + 3'h1;
            2'b01:   count <= count - 3'h1;
            default: count <= count;
          endcase
        end
      end

      // Fallback stands in when the FIFO has run dry
      assign next_word = fifo_empty[ch] ? fallback_value : mem[rd_ptr];

      // Level code: 0xffff highest, 0x8000 midpoint, 0x0000 lowest.
      // Format is applied as the word is taken, so a format change between
      // sample points leaves the held level alone.
      assign level = ctrl.sample_format_sel ? {~next_word[15], next_word[14:0]}
                                            : next_word;

      // Level held for the whole sample period
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cur_word <= 16'h0000;
        end else if (sample_point) begin
          cur_word <= level;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_q[ch] <= '0;
        end else begin
          chan_q[ch].drive     <= run & chan_cfg[ch].output_enable;
          chan_q[ch].mid_drive <= run & chan_cfg[ch].midpoint_enable;
          chan_q[ch].irq       <= chan_cfg[ch].irq_type ? fifo_empty[ch]
                                                        : ~fifo_full[ch];
          chan_q[ch].strobe    <= sample_d;
          chan_q[ch].level     <= cur_word;
        end
      end
    end
  endgenerate

  assign left_chan  = chan_q[0];
  assign right_chan = chan_q[1];

  // ----------------------------------------------------------------
  // APB slave: one wait state, registered answer
  // ----------------------------------------------------------------
  assign access = psel & penable & ~pready;
  assign wr_en  = psel & penable & pready & pwrite & ~pslverr;

  assign port_write[0] = wr_en & (paddr == sadc_pkg::LEFT_PORT_ADDR);
  assign port_write[1] = wr_en & (paddr == sadc_pkg::RIGHT_PORT_ADDR);

  always_comb begin
    addr_ok = (paddr == sadc_pkg::CTRL_ADDR) | (paddr == sadc_pkg::STAT_ADDR)
            | (paddr == sadc_pkg::FALLBACK_ADDR) | (paddr == sadc_pkg::LEFT_PORT_ADDR)
            | (paddr == sadc_pkg::RIGHT_PORT_ADDR);
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb begin
    stat_word = 16'h0000;
    stat_word[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_OE_BIT]     = chan_cfg[0].output_enable;
    stat_word[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_MID_BIT]    = chan_cfg[0].midpoint_enable;
    stat_word[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_TYPE_BIT]   = chan_cfg[0].irq_type;
    stat_word[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_FULL_BIT]   = fifo_full[0];
    stat_word[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_EMPTY_BIT]  = fifo_empty[0];
    stat_word[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_OE_BIT]    = chan_cfg[1].output_enable;
    stat_word[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_MID_BIT]   = chan_cfg[1].midpoint_enable;
    stat_word[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_TYPE_BIT]  = chan_cfg[1].irq_type;
    stat_word[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_FULL_BIT]  = fifo_full[1];
    stat_word[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_EMPTY_BIT] = fifo_empty[1];
  end

  // ----------------------------------------------------------------
  // Read data multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      sadc_pkg::CTRL_ADDR: begin
        next_rdata[sadc_pkg::CTRL_ENABLE_BIT] = ctrl.module_enable;
        next_rdata[sadc_pkg::CTRL_IDLE_BIT]   = ctrl.idle_stop;
        next_rdata[sadc_pkg::CTRL_AMP_BIT]    = ctrl.amp_keep_on;
        next_rdata[sadc_pkg::CTRL_FORMAT_BIT] = ctrl.sample_format_sel;
        next_rdata[sadc_pkg::CTRL_DIV_LSB +: sadc_pkg::DIV_WIDTH] = ctrl.conv_clock_divider;
      end
      sadc_pkg::STAT_ADDR:       next_rdata[15:0] = stat_word;
      sadc_pkg::FALLBACK_ADDR:   next_rdata[15:0] = fallback_value;
      sadc_pkg::LEFT_PORT_ADDR:  next_rdata[15:0] = last_port_word[0];
      sadc_pkg::RIGHT_PORT_ADDR: next_rdata[15:0] = last_port_word[1];
      default:                   next_rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Answering from flops costs a wait state but keeps decode off the ready path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~addr_ok;
      if (access && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '{module_enable: 1'b0, idle_stop: 1'b0, amp_keep_on: 1'b0,
                sample_format_sel: 1'b0, conv_clock_divider: sadc_pkg::DIV_RESET};
    end else if (wr_en && paddr == sadc_pkg::CTRL_ADDR) begin
      ctrl.module_enable      <= pwdata[sadc_pkg::CTRL_ENABLE_BIT];
      ctrl.idle_stop          <= pwdata[sadc_pkg::CTRL_IDLE_BIT];
      ctrl.amp_keep_on        <= pwdata[sadc_pkg::CTRL_AMP_BIT];
      ctrl.sample_format_sel  <= pwdata[sadc_pkg::CTRL_FORMAT_BIT];
      ctrl.conv_clock_divider <= pwdata[sadc_pkg::CTRL_DIV_LSB +: sadc_pkg::DIV_WIDTH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_cfg[0] <= '0;
      chan_cfg[1] <= '0;
    end else if (wr_en && paddr == sadc_pkg::STAT_ADDR) begin
      // Full and empty bits are live state, so writes to them are ignored
      chan_cfg[0].output_enable   <= pwdata[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_OE_BIT];
      chan_cfg[0].midpoint_enable <= pwdata[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_MID_BIT];
      chan_cfg[0].irq_type        <= pwdata[sadc_pkg::LEFT_STAT_BASE + sadc_pkg::STAT_TYPE_BIT];
      chan_cfg[1].output_enable   <= pwdata[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_OE_BIT];
      chan_cfg[1].midpoint_enable <= pwdata[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_MID_BIT];
      chan_cfg[1].irq_type        <= pwdata[sadc_pkg::RIGHT_STAT_BASE + sadc_pkg::STAT_TYPE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fallback_value <= sadc_pkg::FALLBACK_RESET;
    end else if (wr_en && paddr == sadc_pkg::FALLBACK_ADDR) begin
      fallback_value <= pwdata[15:0];
    end
  end

  // Port readback shows the last word written, even one dropped when full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_port_word[0] <= 16'h0000;
      last_port_word[1] <= 16'h0000;
    end else begin
      if (port_write[0]) begin
        last_port_word[0] <= pwdata[15:0];
      end
      if (port_write[1]) begin
        last_port_word[1] <= pwdata[15:0];
      end
    end
  end

endmodule : sadc_top
